// ### shared/osic_cfg.svh
// Register offsets, field positions, reset values and encodings of the status/control bank
`ifndef OSIC_CFG_SVH
`define OSIC_CFG_SVH

`define OSIC_ADDR_MUTE_THR     8'h03
`define OSIC_ADDR_CABLE_LEN    8'h25
`define OSIC_ADDR_A_SWING      8'h30
`define OSIC_ADDR_A_EMPH       8'h31
`define OSIC_ADDR_B_SWING      8'h32
`define OSIC_ADDR_B_EMPH       8'h33
`define OSIC_ADDR_PIN_FUNC     8'h04
`define OSIC_ADDR_INT_MASK     8'h05
`define OSIC_ADDR_INT_STAT     8'h06
`define OSIC_ADDR_EYE_H_THR    8'h07
`define OSIC_ADDR_EYE_V_THR    8'h08

`define OSIC_SWING_OVR_BIT     5
`define OSIC_EMPH_OVR_BIT      6
`define OSIC_CARRIER_SEL_BIT   2

`define OSIC_LEN_MAX           6'h37
`define OSIC_MUTE_THR_RST      6'h3f
`define OSIC_EYE_THR_RST       6'h00
`define OSIC_MASK_RST          7'h00

`define OSIC_INT_LOSS_CABLE_ON  0
`define OSIC_INT_LOSS_CABLE_OFF 1
`define OSIC_INT_LOSS_TRACE_ON  2
`define OSIC_INT_LOSS_TRACE_OFF 3
`define OSIC_INT_EYE_LOW       4
`define OSIC_INT_LOCK_GAIN     5
`define OSIC_INT_LOCK_LOSS     6
`define OSIC_INT_COUNT         7

`define OSIC_CODE_LVL_H        3'h0
`define OSIC_CODE_LVL_F        3'h2
`define OSIC_CODE_LVL_R        3'h3
`define OSIC_CODE_LVL_L        3'h5

`endif

// ### shared/osic_pkg.sv
// Types shared by the status/control bank
package osic_pkg;

   // Four-level strap as resolved by the pad
   typedef enum logic [1:0] {
      OSIC_LVL_L = 2'h0,
      OSIC_LVL_R = 2'h1,
      OSIC_LVL_F = 2'h2,
      OSIC_LVL_H = 2'h3
   } osic_level_e;

   // Status pin function select
   typedef enum logic [1:0] {
      OSIC_PIN_LOCK    = 2'h0,
      OSIC_PIN_CARRIER = 2'h1,
      OSIC_PIN_INT     = 2'h2
   } osic_pin_func_e;

   // Interface selection, one-hot
   typedef enum logic [3:0] {
      OSIC_IF_SMBUS    = 4'h1,
      OSIC_IF_SPI      = 4'h2,
      OSIC_IF_PWR_SAVE = 4'h4,
      OSIC_IF_RESERVED = 4'h8
   } osic_if_mode_e;

   typedef struct packed {
      logic [2:0] swing;
      logic [2:0] emph;
   } osic_drive_s;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } osic_req_s;

   typedef struct packed {
      logic       loss_cable;
      logic       loss_trace;
      logic       carrier_cable;
      logic       carrier_trace;
      logic       adapt_done;
      logic       recovery_locked;
      logic [5:0] horiz_open;
      logic [5:0] vert_open;
      logic [5:0] cable_len;
   } osic_analog_s;

endpackage

// ### logic/osic_ctrl.sv
// Output drive selection, status pin, interrupts, cable length/mute and interface strap
//
// How it works
// - Strap level H/F/R/L sets swing and emphasis codes 0/0, 2/2, 3/3, 5/5.
// - Swing override bit 5 set: that output's swing comes from register bits 2:0.
// - Emphasis override bit 6 set: that output's emphasis comes from bits 2:0.
// - Register-driven codes accept every value 0 to 7.
// - Default pin function pulls low while clock recovery is locked.
// - A register picks pin function: lock, carrier detect or interrupt.
// - Carrier function pulls low once adaptation finishes after carrier is found.
// - A register bit picks cable or trace input for carrier indication.
// - Interrupt function pulls low when any enabled of seven masked sources fires.
// - Loss events on each input are sources with two masks, whatever input is used.
// - Eye opening under threshold while locked is a single-mask source.
// - Lock events are a source with two masks.
// - Interrupt indication is sticky until status register is read.
// - Read-only 6-bit cable length estimate reports 0 to 55.
// - Outputs mute when estimated length exceeds the 6-bit threshold.
// - Threshold shares the estimate's scale; its meaning follows data rate.
// - Interface strap at power-up: H power save, F SPI, R reserved, L SMBus.
`include "osic_cfg.svh"

module osic_ctrl #(
   parameter int CODE_W = 3,
   parameter int LEN_W  = 6
) (
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   input  wire osic_pkg::osic_req_s    req,
   output logic [7:0]                  rd_data,
   output logic                        rd_valid,
   input  wire osic_pkg::osic_level_e  swing_emphasis_strap,
   input  wire osic_pkg::osic_level_e  mode_strap,
   input  wire osic_pkg::osic_analog_s ana,
   output osic_pkg::osic_drive_s       output_a_drive,
   output osic_pkg::osic_drive_s       output_b_drive,
   output logic                        outputs_mute,
   output logic                        status_pin_o,
   output logic                        status_pin_oe,
   output osic_pkg::osic_if_mode_e     if_mode
);

   // Register storage
   logic [5:0]                  mute_thr_r;
   logic [7:0]                  a_swing_r;
   logic [7:0]                  a_emph_r;
   logic [7:0]                  b_swing_r;
   logic [7:0]                  b_emph_r;
   logic [2:0]                  pin_func_r;
   logic [`OSIC_INT_COUNT-1:0]  int_mask_r;
   logic [`OSIC_INT_COUNT-1:0]  int_stat_r;
   logic [`OSIC_INT_COUNT-1:0]  int_stat_nxt;
   logic [5:0]                  eye_h_thr_r;
   logic [5:0]                  eye_v_thr_r;
   logic [7:0]                  rd_data_nxt;

   // Previous-cycle copies for edge detection, and the once-only strap flag
   logic                        loss_cable_q;
   logic                        loss_trace_q;
   logic                        locked_q;
   logic                        eye_low_q;
   logic                        strap_taken_r;

   // Write strobes and the status-read clear strobe
   wire wr_mute   = req.wr && (req.addr == `OSIC_ADDR_MUTE_THR);
   wire wr_a_sw   = req.wr && (req.addr == `OSIC_ADDR_A_SWING);
   wire wr_a_em   = req.wr && (req.addr == `OSIC_ADDR_A_EMPH);
   wire wr_b_sw   = req.wr && (req.addr == `OSIC_ADDR_B_SWING);
   wire wr_b_em   = req.wr && (req.addr == `OSIC_ADDR_B_EMPH);
   wire wr_func   = req.wr && (req.addr == `OSIC_ADDR_PIN_FUNC);
   wire wr_mask   = req.wr && (req.addr == `OSIC_ADDR_INT_MASK);
   wire wr_eye_h  = req.wr && (req.addr == `OSIC_ADDR_EYE_H_THR);
   wire wr_eye_v  = req.wr && (req.addr == `OSIC_ADDR_EYE_V_THR);
   wire rd_stat   = req.rd && (req.addr == `OSIC_ADDR_INT_STAT);

   // Strap decode shared by both outputs
   function automatic logic [CODE_W-1:0] strap_code(input osic_pkg::osic_level_e lvl);
      case (lvl)
         osic_pkg::OSIC_LVL_H: strap_code = `OSIC_CODE_LVL_H;
         osic_pkg::OSIC_LVL_F: strap_code = `OSIC_CODE_LVL_F;
         osic_pkg::OSIC_LVL_R: strap_code = `OSIC_CODE_LVL_R;
         default:              strap_code = `OSIC_CODE_LVL_L;
      endcase
   endfunction

   // Override selection, used four times
   function automatic logic [CODE_W-1:0] pick_code(input logic [7:0] ctrl,
                                                   input int unsigned ovr_bit,
                                                   input logic [CODE_W-1:0] strap);
      pick_code = ctrl[ovr_bit] ? ctrl[CODE_W-1:0] : strap;
   endfunction

   wire [CODE_W-1:0] strap_val = strap_code(swing_emphasis_strap);

   osic_pkg::osic_drive_s a_drive_nxt;
   osic_pkg::osic_drive_s b_drive_nxt;
   assign a_drive_nxt.swing = pick_code(a_swing_r, `OSIC_SWING_OVR_BIT, strap_val);
   assign a_drive_nxt.emph  = pick_code(a_emph_r, `OSIC_EMPH_OVR_BIT, strap_val);
   assign b_drive_nxt.swing = pick_code(b_swing_r, `OSIC_SWING_OVR_BIT, strap_val);
   assign b_drive_nxt.emph  = pick_code(b_emph_r, `OSIC_EMPH_OVR_BIT, strap_val);

   // Estimate clipped to its documented range
   wire [LEN_W-1:0] cable_len_clip =
      (ana.cable_len > `OSIC_LEN_MAX) ? `OSIC_LEN_MAX : ana.cable_len;

   // Same scale for both; rate dependence is carried by the analog estimate
   wire mute_nxt = (cable_len_clip > mute_thr_r);

   // Interrupt sources
   wire eye_low = ana.recovery_locked &&
                  ((ana.horiz_open < eye_h_thr_r) || (ana.vert_open < eye_v_thr_r));

   logic [`OSIC_INT_COUNT-1:0] int_event;
   assign int_event[`OSIC_INT_LOSS_CABLE_ON]  = ana.loss_cable && !loss_cable_q;
   assign int_event[`OSIC_INT_LOSS_CABLE_OFF] = !ana.loss_cable && loss_cable_q;
   assign int_event[`OSIC_INT_LOSS_TRACE_ON]  = ana.loss_trace && !loss_trace_q;
   assign int_event[`OSIC_INT_LOSS_TRACE_OFF] = !ana.loss_trace && loss_trace_q;
   assign int_event[`OSIC_INT_EYE_LOW]       = eye_low && !eye_low_q;
   assign int_event[`OSIC_INT_LOCK_GAIN]     = ana.recovery_locked && !locked_q;
   assign int_event[`OSIC_INT_LOCK_LOSS]     = !ana.recovery_locked && locked_q;

   // A new event in the clearing cycle survives the read
   assign int_stat_nxt = (rd_stat ? '0 : int_stat_r) | int_event;

   wire int_pending = |(int_stat_r & int_mask_r);

   // Status pin source
   wire carrier_sel  = pin_func_r[`OSIC_CARRIER_SEL_BIT];
   wire carrier_ok   = (carrier_sel ? ana.carrier_trace : ana.carrier_cable)
                       && ana.adapt_done;
   wire [1:0] func   = pin_func_r[1:0];
   logic pull_low_nxt;
   always_comb begin
      case (func)
         osic_pkg::OSIC_PIN_LOCK:    pull_low_nxt = ana.recovery_locked;
         osic_pkg::OSIC_PIN_CARRIER: pull_low_nxt = carrier_ok;
         osic_pkg::OSIC_PIN_INT:     pull_low_nxt = int_pending;
         default:                    pull_low_nxt = ana.recovery_locked;
      endcase
   end

   // Read mux; unmapped addresses return zero
   always_comb begin
      case (req.addr)
         `OSIC_ADDR_MUTE_THR:  rd_data_nxt = {2'h0, mute_thr_r};
         `OSIC_ADDR_CABLE_LEN: rd_data_nxt = {2'h0, cable_len_clip};
         `OSIC_ADDR_A_SWING:   rd_data_nxt = a_swing_r;
         `OSIC_ADDR_A_EMPH:    rd_data_nxt = a_emph_r;
         `OSIC_ADDR_B_SWING:   rd_data_nxt = b_swing_r;
         `OSIC_ADDR_B_EMPH:    rd_data_nxt = b_emph_r;
         `OSIC_ADDR_PIN_FUNC:  rd_data_nxt = {5'h00, pin_func_r};
         `OSIC_ADDR_INT_MASK:  rd_data_nxt = {1'h0, int_mask_r};
         `OSIC_ADDR_INT_STAT:  rd_data_nxt = {1'h0, int_stat_r};
         `OSIC_ADDR_EYE_H_THR: rd_data_nxt = {2'h0, eye_h_thr_r};
         `OSIC_ADDR_EYE_V_THR: rd_data_nxt = {2'h0, eye_v_thr_r};
         default:              rd_data_nxt = 8'h00;
      endcase
   end

   // Only the used bits are stored; the rest read back as zero
   wire [7:0] sw_mask = 8'h27;
   wire [7:0] em_mask = 8'h47;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         mute_thr_r  <= `OSIC_MUTE_THR_RST;
         a_swing_r   <= 8'h00;
         a_emph_r    <= 8'h00;
         b_swing_r   <= 8'h00;
         b_emph_r    <= 8'h00;
         pin_func_r  <= 3'h0;
         int_mask_r  <= `OSIC_MASK_RST;
         eye_h_thr_r <= `OSIC_EYE_THR_RST;
         eye_v_thr_r <= `OSIC_EYE_THR_RST;
      end else begin
         if (wr_mute)  mute_thr_r  <= req.wdata[5:0];
         if (wr_a_sw)  a_swing_r   <= req.wdata & sw_mask;
         if (wr_a_em)  a_emph_r    <= req.wdata & em_mask;
         if (wr_b_sw)  b_swing_r   <= req.wdata & sw_mask;
         if (wr_b_em)  b_emph_r    <= req.wdata & em_mask;
         if (wr_func)  pin_func_r  <= req.wdata[2:0];
         if (wr_mask)  int_mask_r  <= req.wdata[`OSIC_INT_COUNT-1:0];
         if (wr_eye_h) eye_h_thr_r <= req.wdata[5:0];
         if (wr_eye_v) eye_v_thr_r <= req.wdata[5:0];
      end
   end

   // Edge history starts idle, so a source already active at release fires once
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         loss_cable_q <= 1'b0;
         loss_trace_q <= 1'b0;
         locked_q     <= 1'b0;
         eye_low_q    <= 1'b0;
         int_stat_r   <= '0;
      end else begin
         loss_cable_q <= ana.loss_cable;
         loss_trace_q <= ana.loss_trace;
         locked_q     <= ana.recovery_locked;
         eye_low_q    <= eye_low;
         int_stat_r   <= int_stat_nxt;
      end
   end

   // Registered outputs
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         output_a_drive <= '0;
         output_b_drive <= '0;
         outputs_mute   <= 1'b0;
         status_pin_o   <= 1'b0;
         status_pin_oe  <= 1'b0;
         rd_data        <= 8'h00;
         rd_valid       <= 1'b0;
      end else begin
         output_a_drive <= a_drive_nxt;
         output_b_drive <= b_drive_nxt;
         outputs_mute   <= mute_nxt;
         status_pin_oe  <= pull_low_nxt;
         rd_valid       <= req.rd;
         if (req.rd) rd_data <= rd_data_nxt;
      end
   end

   // Strap caught once after release; later moves are ignored
   osic_pkg::osic_if_mode_e if_mode_nxt;
   always_comb begin
      case (mode_strap)
         osic_pkg::OSIC_LVL_H: if_mode_nxt = osic_pkg::OSIC_IF_PWR_SAVE;
         osic_pkg::OSIC_LVL_F: if_mode_nxt = osic_pkg::OSIC_IF_SPI;
         osic_pkg::OSIC_LVL_R: if_mode_nxt = osic_pkg::OSIC_IF_RESERVED;
         default:              if_mode_nxt = osic_pkg::OSIC_IF_SMBUS;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         strap_taken_r <= 1'b0;
         if_mode       <= osic_pkg::OSIC_IF_SMBUS;
      end else if (!strap_taken_r) begin
         strap_taken_r <= 1'b1;
         if_mode       <= if_mode_nxt;
      end
   end

endmodule

// ### test/osic_ctrl_properties.sv
// Port-level checks on the status/control bank
`include "osic_cfg.svh"

module osic_ctrl_properties (
   input wire logic                   clk,
   input wire logic                   sys_rst,
   input wire osic_pkg::osic_req_s    req,
   input wire logic [7:0]             rd_data,
   input wire logic                   rd_valid,
   input wire osic_pkg::osic_level_e  swing_emphasis_strap,
   input wire osic_pkg::osic_level_e  mode_strap,
   input wire osic_pkg::osic_analog_s ana,
   input wire osic_pkg::osic_drive_s  output_a_drive,
   input wire osic_pkg::osic_drive_s  output_b_drive,
   input wire logic                   outputs_mute,
   input wire logic                   status_pin_o,
   input wire logic                   status_pin_oe,
   input wire osic_pkg::osic_if_mode_e if_mode
);
   timeunit 1ns;
   timeprecision 1ps;

   // Mirrors of written state, so pin and drive checks know the selected behaviour
   logic [2:0] func_r;
   logic [3:0] ovr_r;
   logic [5:0] thr_r;
   wire  [5:0] len_clip = (ana.cable_len > `OSIC_LEN_MAX) ? `OSIC_LEN_MAX : ana.cable_len;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         func_r <= 3'h0;
         ovr_r <= 4'h0;
         thr_r <= `OSIC_MUTE_THR_RST;
      end else if (req.wr) begin
         case (req.addr)
            `OSIC_ADDR_PIN_FUNC: func_r <= req.wdata[2:0];
            `OSIC_ADDR_MUTE_THR: thr_r <= req.wdata[5:0];
            `OSIC_ADDR_A_SWING: ovr_r[0] <= req.wdata[`OSIC_SWING_OVR_BIT];
            `OSIC_ADDR_A_EMPH: ovr_r[1] <= req.wdata[`OSIC_EMPH_OVR_BIT];
            `OSIC_ADDR_B_SWING: ovr_r[2] <= req.wdata[`OSIC_SWING_OVR_BIT];
            `OSIC_ADDR_B_EMPH: ovr_r[3] <= req.wdata[`OSIC_EMPH_OVR_BIT];
            default: ;
         endcase
      end
   end

   function automatic logic [2:0] code(input osic_pkg::osic_level_e l);
      return (l == osic_pkg::OSIC_LVL_H) ? `OSIC_CODE_LVL_H :
             (l == osic_pkg::OSIC_LVL_F) ? `OSIC_CODE_LVL_F :
             (l == osic_pkg::OSIC_LVL_R) ? `OSIC_CODE_LVL_R : `OSIC_CODE_LVL_L;
   endfunction

   function automatic logic [3:0] mmap(input osic_pkg::osic_level_e l);
      return (l == osic_pkg::OSIC_LVL_H) ? osic_pkg::OSIC_IF_PWR_SAVE :
             (l == osic_pkg::OSIC_LVL_F) ? osic_pkg::OSIC_IF_SPI :
             (l == osic_pkg::OSIC_LVL_R) ? osic_pkg::OSIC_IF_RESERVED : osic_pkg::OSIC_IF_SMBUS;
   endfunction

   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_release;
      $past(sys_rst) && !sys_rst;
   endsequence

   property p_mode_map;
      s_release |=> if_mode == mmap($past(mode_strap));
   endproperty
   property p_mode_hold;
      !$past(sys_rst) && !$past(sys_rst, 2) |-> $stable(if_mode);
   endproperty
   property p_strap;
      !$past(sys_rst) && $past(ovr_r) == 4'h0 |->
         output_a_drive == {2{code($past(swing_emphasis_strap))}} && output_b_drive == output_a_drive;
   endproperty
   property p_lock_pin;
      !$past(sys_rst) && $past(func_r[0]) == $past(func_r[1]) |->
         status_pin_oe == $past(ana.recovery_locked);
   endproperty
   property p_carrier;
      $past(func_r[1:0]) == 2'h1 && status_pin_oe |->
         $past(ana.adapt_done && (func_r[2] ? ana.carrier_trace : ana.carrier_cable));
   endproperty
   property p_mute;
      !$past(sys_rst) |-> outputs_mute == ($past(len_clip) > $past(thr_r));
   endproperty
   property p_len_read;
      req.rd && req.addr == `OSIC_ADDR_CABLE_LEN |=> rd_valid && rd_data <= 8'h37;
   endproperty
   property p_pin_drive;
      status_pin_oe |-> !status_pin_o;
   endproperty

   a_mode_map: assert property (p_mode_map) else $error("if_mode not taken from strap");
   a_mode_hold: assert property (p_mode_hold) else $error("if_mode moved");
   a_strap: assert property (p_strap) else $error("strap codes wrong");
   a_lock_pin: assert property (p_lock_pin) else $error("lock pin wrong");
   a_carrier: assert property (p_carrier) else $error("carrier pin early");
   a_mute: assert property (p_mute) else $error("mute wrong");
   a_len_read: assert property (p_len_read) else $error("length read wrong");
   a_pin_drive: assert property (p_pin_drive) else $error("pin drives high");
endmodule

bind osic_ctrl osic_ctrl_properties osic_ctrl_properties_i (.clk(clk), .sys_rst(sys_rst),
   .req(req), .rd_data(rd_data), .rd_valid(rd_valid),
   .swing_emphasis_strap(swing_emphasis_strap), .mode_strap(mode_strap), .ana(ana),
   .output_a_drive(output_a_drive), .output_b_drive(output_b_drive),
   .outputs_mute(outputs_mute), .status_pin_o(status_pin_o),
   .status_pin_oe(status_pin_oe), .if_mode(if_mode));

// ### test/osic_host_model.sv
// Host-side register access model for the status/control bank
module osic_host_model (
   input  wire logic           clk,
   input  wire logic           rd_valid,
   input  wire logic [7:0]     rd_data,
   output osic_pkg::osic_req_s req
);
   timeunit 1ns;
   timeprecision 1ps;

   initial req = '0;

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{1'b1, 1'b0, a, d};
      @(posedge clk);
      req <= '0;
   endtask

   // No answer pulse gives unknown data, so a silent port cannot pass a compare
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk);
      req <= '0;
      @(posedge clk);
      d = (rd_valid === 1'b1) ? rd_data : 8'hxx;
   endtask
endmodule

// ### test/output_status_interrupt_control_tb.sv
// Self-checking bench for the status/control bank
module output_status_interrupt_control_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic                    clk;
   logic                    sys_rst;
   osic_pkg::osic_req_s     req;
   logic [7:0]              rd_data;
   logic                    rd_valid;
   osic_pkg::osic_level_e   sstrap;
   osic_pkg::osic_level_e   mstrap;
   osic_pkg::osic_analog_s  ana;
   osic_pkg::osic_drive_s   drv_a;
   osic_pkg::osic_drive_s   drv_b;
   logic                    mute;
   logic                    pin_o;
   logic                    pin_oe;
   osic_pkg::osic_if_mode_e if_mode;
   logic [7:0]              d;
   int                      errors;
   int                      n_checks;
   int                      cycles = 0;
   logic [2:0]              code_tb [4] = '{3'h5, 3'h3, 3'h2, 3'h0};

   osic_ctrl osic_ctrl_i (.clk(clk), .sys_rst(sys_rst), .req(req), .rd_data(rd_data),
      .rd_valid(rd_valid), .swing_emphasis_strap(sstrap), .mode_strap(mstrap), .ana(ana),
      .output_a_drive(drv_a), .output_b_drive(drv_b), .outputs_mute(mute),
      .status_pin_o(pin_o), .status_pin_oe(pin_oe), .if_mode(if_mode));
   osic_host_model osic_host_model_i (.clk(clk), .rd_valid(rd_valid), .rd_data(rd_data),
      .req(req));

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      n_checks++;
      if (s !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic w(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Whole run is under two hundred cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         errors++;
         finish_test();
      end
   end

   initial begin
      sys_rst = 1'b1;
      ana = '0;
      ana.recovery_locked = 1'b1;
      ana.horiz_open = 6'h3f;
      ana.vert_open = 6'h3f;
      sstrap = osic_pkg::OSIC_LVL_F;
      mstrap = osic_pkg::OSIC_LVL_F;
      errors = 0;
      n_checks = 0;
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      w(2);
      chk("if_mode", 8'h02, {4'h0, if_mode});
      @(posedge clk) mstrap <= osic_pkg::OSIC_LVL_R;
      w(3);
      chk("if_mode held", 8'h02, {4'h0, if_mode});
      chk("lock pin", 8'h01, {7'h0, pin_oe});
      osic_host_model_i.rd(8'h03, d);
      chk("mute thr", 8'h3f, d);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk) sstrap <= osic_pkg::osic_level_e'(i);
         w(3);
         chk("drive a", {2'h0, {2{code_tb[i]}}}, {2'h0, drv_a});
         chk("drive b", {2'h0, {2{code_tb[i]}}}, {2'h0, drv_b});
      end
      osic_host_model_i.wr(8'h30, 8'h27);
      osic_host_model_i.wr(8'h33, 8'h46);
      w(2);
      chk("drive a ovr", 8'h38, {2'h0, drv_a});
      chk("drive b ovr", 8'h06, {2'h0, drv_b});
      osic_host_model_i.rd(8'h30, d);
      chk("swing reg", 8'h27, d);
      @(posedge clk) ana.cable_len <= 6'h3c;
      w(2);
      osic_host_model_i.wr(8'h25, 8'h00);
      osic_host_model_i.rd(8'h25, d);
      chk("length clip", 8'h37, d);
      @(posedge clk) ana.cable_len <= 6'h14;
      w(2);
      osic_host_model_i.rd(8'h25, d);
      osic_host_model_i.wr(8'h03, d);
      w(2);
      chk("mute at thr", 8'h00, {7'h0, mute});
      @(posedge clk) ana.cable_len <= 6'h15;
      w(3);
      chk("mute over", 8'h01, {7'h0, mute});
      @(posedge clk) ana.recovery_locked <= 1'b0;
      w(3);
      chk("unlock pin", 8'h00, {7'h0, pin_oe});
      osic_host_model_i.wr(8'h04, 8'h01);
      @(posedge clk) ana.carrier_cable <= 1'b1;
      w(3);
      chk("carrier unadapted", 8'h00, {7'h0, pin_oe});
      @(posedge clk) ana.adapt_done <= 1'b1;
      w(3);
      chk("carrier pin", 8'h01, {7'h0, pin_oe});
      osic_host_model_i.wr(8'h04, 8'h05);
      w(2);
      chk("trace no carrier", 8'h00, {7'h0, pin_oe});
      @(posedge clk) ana.carrier_trace <= 1'b1;
      w(3);
      chk("trace carrier", 8'h01, {7'h0, pin_oe});
      osic_host_model_i.wr(8'h07, 8'h10);
      osic_host_model_i.wr(8'h04, 8'h02);
      osic_host_model_i.rd(8'h06, d);
      // One edge of every source, with the mask closed
      for (int i = 0; i < 7; i++) begin
         @(posedge clk);
         case (i)
            0: ana.loss_cable <= 1'b1;
            1: ana.loss_cable <= 1'b0;
            2: ana.loss_trace <= 1'b1;
            3: ana.loss_trace <= 1'b0;
            4: ana.recovery_locked <= 1'b1;
            5: ana.horiz_open <= 6'h08;
            default: ana.recovery_locked <= 1'b0;
         endcase
         w(2);
      end
      w(2);
      chk("int masked", 8'h00, {7'h0, pin_oe});
      osic_host_model_i.wr(8'h05, 8'h40);
      w(3);
      chk("int pin", 8'h01, {7'h0, pin_oe});
      w(8);
      chk("int sticky", 8'h01, {7'h0, pin_oe});
      osic_host_model_i.rd(8'h06, d);
      chk("int status", 8'h7f, d);
      w(3);
      chk("int cleared", 8'h00, {7'h0, pin_oe});
      osic_host_model_i.rd(8'h06, d);
      chk("status empty", 8'h00, d);
      // Second power-up: strap now at H, state must return to defaults
      @(posedge clk) sys_rst <= 1'b1;
      mstrap <= osic_pkg::OSIC_LVL_H;
      ana.recovery_locked <= 1'b1;
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      w(2);
      chk("if_mode pwr save", 8'h04, {4'h0, if_mode});
      chk("drive a reset", 8'h00, {2'h0, drv_a});
      chk("mute reset", 8'h00, {7'h0, mute});
      chk("lock pin reset", 8'h01, {7'h0, pin_oe});
      finish_test();
   end
endmodule
